// >>> pkg/ccdo_pkg.sv
// shared constants and types for the call, clear and decrement executer
package ccdo_pkg;
   localparam int PC_W = 13;
   localparam int LIT_W = 11;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int FILE_DEPTH = 128;
   localparam int LATCH_LO = 3;
   localparam int LATCH_HI = 4;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
   localparam logic [7:0] DOG_CLEAR = 8'h00;
   localparam logic [7:0] PRESCALE_CLEAR = 8'h00;

   typedef enum logic [2:0] {
      CCDO_OP_NOP = 3'h0,
      CCDO_OP_CALL = 3'h1,
      CCDO_OP_DOG_KICK = 3'h2,
      CCDO_OP_FILE_ZERO = 3'h3,
      CCDO_OP_FILE_INV = 3'h4,
      CCDO_OP_ACC_ZERO = 3'h5,
      CCDO_OP_FILE_DEC = 3'h6,
      CCDO_OP_DEC_SKIP = 3'h7
   } ccdo_op_t;

   // execute-stage states, run -> call2 flips one bit, run -> skip2 flips two bits
   typedef enum logic [1:0] {
      CCDO_ST_RUN = 2'b00,
      CCDO_ST_CALL2 = 2'b01,
      CCDO_ST_SKIP2 = 2'b11
   } ccdo_state_t;

   typedef struct packed {
      logic valid;
      ccdo_op_t op;
      logic [LIT_W-1:0] lit;
      logic [ADDR_W-1:0] addr;
      logic dest;
   } ccdo_instr_t;

   typedef struct packed {
      logic push;
      logic [PC_W-1:0] data;
   } ccdo_push_t;

   typedef struct packed {
      logic zero;
      logic expiry_n;
      logic sleep_n;
   } ccdo_flags_t;
endpackage : ccdo_pkg

// >>> rtl/ccdo_core.sv
// execute stage for call, watchdog kick, clears, invert and decrements
// Overview of operation
// - call pushes current pc plus one onto the return stack top
// - call loads its eleven-bit literal into pc bits 10 to 0
// - call takes pc 12:11 from latch 4:3, keeps flags, two cycles
// - watchdog kick zeroes the watchdog counter and its prescaler
// - watchdog kick sets expiry and sleep flags, no other flag
// - file zero clears the addressed register and sets the zero flag
// - file invert complements register into accumulator or register, updates zero
// - accumulator zero clears the accumulator and sets the zero flag
// - file minus one decrements register, routes by destination, updates zero
// - skip decrement routes like plain decrement and keeps all flags
// - zero result of skip decrement discards next instruction, runs no-op
module ccdo_core (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // instruction in
   input wire ccdo_pkg::ccdo_instr_t instr,
   output logic instr_ready,
   // upper pc latch
   input wire logic [7:0] upper_pc_latch,
   // program counter and stack
   output logic [ccdo_pkg::PC_W-1:0] pc_q,
   output ccdo_pkg::ccdo_push_t stack_push,
   output logic [ccdo_pkg::PC_W-1:0] stack_top,
   // accumulator and flags
   output logic [ccdo_pkg::DATA_W-1:0] accum_q,
   output ccdo_pkg::ccdo_flags_t flags_q,
   // watchdog
   output logic [7:0] watchdog_counter,
   output logic [7:0] prescaler_q,
   input wire logic watchdog_tick,
   // discard marker for next fetched instruction
   output logic discard_q,
   // register file debug read
   input wire logic [ccdo_pkg::ADDR_W-1:0] dbg_addr,
   output logic [ccdo_pkg::DATA_W-1:0] dbg_data
);
   ccdo_pkg::ccdo_state_t state_q;
   ccdo_pkg::ccdo_state_t state_d;
   ccdo_pkg::ccdo_instr_t held_q;
   logic [ccdo_pkg::DATA_W-1:0] rd_data;
   logic [ccdo_pkg::PC_W-1:0] pc_d;
   logic [ccdo_pkg::DATA_W-1:0] accum_d;
   ccdo_pkg::ccdo_flags_t flags_d;
   logic [7:0] dog_d;
   logic [7:0] pre_d;
   logic [ccdo_pkg::DATA_W-1:0] result;
   logic wr_en;
   logic [ccdo_pkg::PC_W-1:0] stack_top_d;
   logic discard_d;
   logic push_d;

   // operand fetch: address read one cycle, execute the next
   wire take = instr.valid && (state_q == ccdo_pkg::CCDO_ST_RUN);
   wire busy_exec = held_q.valid;
   wire ccdo_pkg::ccdo_op_t op = held_q.op;
   wire [ccdo_pkg::DATA_W-1:0] inv_val = ~rd_data;
   wire [ccdo_pkg::DATA_W-1:0] dec_val = rd_data - ccdo_pkg::ONE_BYTE;
   wire dec_zero = (dec_val == ccdo_pkg::ZERO_BYTE);
   wire is_file_wr = (op == ccdo_pkg::CCDO_OP_FILE_ZERO)
      || (((op == ccdo_pkg::CCDO_OP_FILE_INV) || (op == ccdo_pkg::CCDO_OP_FILE_DEC)
      || (op == ccdo_pkg::CCDO_OP_DEC_SKIP)) && held_q.dest);
   wire to_accum = ((op == ccdo_pkg::CCDO_OP_FILE_INV) || (op == ccdo_pkg::CCDO_OP_FILE_DEC)
      || (op == ccdo_pkg::CCDO_OP_DEC_SKIP)) && !held_q.dest;
   wire [ccdo_pkg::PC_W-1:0] call_target = {upper_pc_latch[ccdo_pkg::LATCH_HI:ccdo_pkg::LATCH_LO],
      held_q.lit};

   assign instr_ready = (state_q == ccdo_pkg::CCDO_ST_RUN);

   ccdo_file_ram u_ram (
      .mclk(mclk),
      .rd_addr(take ? instr.addr : dbg_addr),
      .rd_data(rd_data),
      .wr_en(wr_en),
      .wr_addr(held_q.addr),
      .wr_data(result)
   );
   assign dbg_data = rd_data;

   always_comb begin
      result = ccdo_pkg::ZERO_BYTE;
      unique case (op)
         ccdo_pkg::CCDO_OP_FILE_INV: result = inv_val;
         ccdo_pkg::CCDO_OP_FILE_DEC, ccdo_pkg::CCDO_OP_DEC_SKIP: result = dec_val;
         default: result = ccdo_pkg::ZERO_BYTE;
      endcase
   end

   always_comb begin
      pc_d = pc_q;
      accum_d = accum_q;
      flags_d = flags_q;
      dog_d = watchdog_tick ? 8'(watchdog_counter + 8'h01) : watchdog_counter;
      pre_d = watchdog_tick ? 8'(prescaler_q + 8'h01) : prescaler_q;
      wr_en = 1'b0;
      stack_top_d = stack_top;
      push_d = 1'b0;
      discard_d = 1'b0;
      state_d = state_q;
      if (take) begin
         pc_d = pc_q + ccdo_pkg::PC_STEP;
      end
      if (busy_exec && state_q == ccdo_pkg::CCDO_ST_RUN) begin
         wr_en = is_file_wr;
         if (to_accum) begin
            accum_d = result;
         end
         unique case (op)
            ccdo_pkg::CCDO_OP_CALL: begin
               push_d = 1'b1;
               stack_top_d = pc_q;
               pc_d = call_target;
               state_d = ccdo_pkg::CCDO_ST_CALL2;
            end
            ccdo_pkg::CCDO_OP_DOG_KICK: begin
               dog_d = ccdo_pkg::DOG_CLEAR;
               pre_d = ccdo_pkg::PRESCALE_CLEAR;
               flags_d.expiry_n = 1'b1;
               flags_d.sleep_n = 1'b1;
            end
            ccdo_pkg::CCDO_OP_FILE_ZERO: flags_d.zero = 1'b1;
            ccdo_pkg::CCDO_OP_ACC_ZERO: begin
               accum_d = ccdo_pkg::ZERO_BYTE;
               flags_d.zero = 1'b1;
            end
            ccdo_pkg::CCDO_OP_FILE_INV: flags_d.zero = (inv_val == ccdo_pkg::ZERO_BYTE);
            ccdo_pkg::CCDO_OP_FILE_DEC: flags_d.zero = dec_zero;
            ccdo_pkg::CCDO_OP_DEC_SKIP: begin
               if (dec_zero) begin
                  discard_d = 1'b1;
                  pc_d = pc_q + ccdo_pkg::PC_STEP;
                  state_d = ccdo_pkg::CCDO_ST_SKIP2;
               end
            end
            default: begin
            end
         endcase
      end else if (state_q != ccdo_pkg::CCDO_ST_RUN) begin
         state_d = ccdo_pkg::CCDO_ST_RUN;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= ccdo_pkg::CCDO_ST_RUN;
         held_q <= '0;
         pc_q <= ccdo_pkg::PC_RESET;
         accum_q <= ccdo_pkg::ZERO_BYTE;
         flags_q <= '{zero: 1'b0, expiry_n: 1'b1, sleep_n: 1'b1};
         watchdog_counter <= ccdo_pkg::DOG_CLEAR;
         prescaler_q <= ccdo_pkg::PRESCALE_CLEAR;
         stack_push <= '0;
         stack_top <= ccdo_pkg::PC_RESET;
         discard_q <= 1'b0;
      end else begin
         state_q <= state_d;
         held_q <= take ? instr : '0;
         pc_q <= pc_d;
         accum_q <= accum_d;
         flags_q <= flags_d;
         watchdog_counter <= dog_d;
         prescaler_q <= pre_d;
         stack_push <= '{push: push_d, data: stack_top_d};
         stack_top <= stack_top_d;
         discard_q <= discard_d;
      end
   end
endmodule : ccdo_core

// >>> rtl/ccdo_file_ram.sv
// register file, 128 bytes, registered read
module ccdo_file_ram (
   // clock
   input wire logic mclk,
   // read port
   input wire logic [ccdo_pkg::ADDR_W-1:0] rd_addr,
   output logic [ccdo_pkg::DATA_W-1:0] rd_data,
   // write port
   input wire logic wr_en,
   input wire logic [ccdo_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [ccdo_pkg::DATA_W-1:0] wr_data
);
   logic [ccdo_pkg::DATA_W-1:0] mem [ccdo_pkg::FILE_DEPTH];

   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : ccdo_file_ram

// >>> test/ccdo_core_assertions.sv
// checker for the call, clear and decrement executer
module ccdo_core_assertions (
   // clock and instruction
   input wire logic mclk,
   input wire logic rst,
   input wire ccdo_pkg::ccdo_instr_t instr,
   input wire logic instr_ready,
   input wire logic [7:0] upper_pc_latch,
   // results
   input wire logic [ccdo_pkg::PC_W-1:0] pc_q,
   input wire ccdo_pkg::ccdo_push_t stack_push,
   input wire logic [ccdo_pkg::DATA_W-1:0] accum_q,
   input wire ccdo_pkg::ccdo_flags_t flags_q,
   input wire logic [7:0] watchdog_counter,
   input wire logic [7:0] prescaler_q,
   input wire logic discard_q
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence took(o);
      instr.valid && instr_ready && instr.op == o;
   endsequence
   call_push_a: assert property (took(ccdo_pkg::CCDO_OP_CALL) |-> ##2 stack_push.push &&
      stack_push.data == $past(pc_q, 2) + 13'h0001) else $error("call push wrong");
   call_target_a: assert property (took(ccdo_pkg::CCDO_OP_CALL) |-> ##2
      pc_q == {$past(upper_pc_latch[4:3], 2), $past(instr.lit, 2)}) else $error("call target wrong");
   call_stall_a: assert property (took(ccdo_pkg::CCDO_OP_CALL) |-> ##2 !instr_ready
      ##1 instr_ready) else $error("call length wrong");
   flags_keep_a: assert property ((took(ccdo_pkg::CCDO_OP_CALL)
      or took(ccdo_pkg::CCDO_OP_DEC_SKIP)) |-> ##2 flags_q == $past(flags_q)) else $error("flags moved");
   kick_clear_a: assert property (took(ccdo_pkg::CCDO_OP_DOG_KICK) |-> ##2 watchdog_counter == 8'h00
      && prescaler_q == 8'h00) else $error("watchdog not cleared");
   kick_flags_a: assert property (took(ccdo_pkg::CCDO_OP_DOG_KICK) |-> ##2 flags_q.expiry_n
      && flags_q.sleep_n && flags_q.zero == $past(flags_q.zero)) else $error("kick flags wrong");
   clear_zero_a: assert property ((took(ccdo_pkg::CCDO_OP_FILE_ZERO)
      or took(ccdo_pkg::CCDO_OP_ACC_ZERO)) |-> ##2 flags_q.zero) else $error("zero flag not set");
   acc_clear_a: assert property (took(ccdo_pkg::CCDO_OP_ACC_ZERO) |-> ##2 accum_q == 8'h00)
      else $error("accumulator not cleared");
   skip_drop_a: assert property (took(ccdo_pkg::CCDO_OP_DEC_SKIP) ##2 discard_q |-> !instr_ready
      ##1 instr_ready) else $error("skip length wrong");
   one_cycle_a: assert property ((took(ccdo_pkg::CCDO_OP_FILE_DEC)
      or took(ccdo_pkg::CCDO_OP_FILE_INV)) |-> ##2 instr_ready && !discard_q) else $error("op too long");
endmodule : ccdo_core_assertions
bind ccdo_core ccdo_core_assertions u_chk (.mclk, .rst, .instr, .instr_ready, .upper_pc_latch,
   .pc_q, .stack_push, .accum_q, .flags_q, .watchdog_counter, .prescaler_q, .discard_q);

// >>> test/test_ccdo_core.sv
// self-checking bench for the call, clear and decrement executer
module test_ccdo_core;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] acc;
      logic z;
      logic [12:0] pc;
      logic push;
      logic [12:0] ret;
      logic disc;
      logic wd0;
      logic [12:0] top;
   } ccdo_exp_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic watchdog_tick = 1'b0;
   logic [7:0] upper_pc_latch = 8'h00;
   ccdo_pkg::ccdo_instr_t instr = '0;
   logic instr_ready, discard_q, t, tk;
   logic [12:0] pc_q, pc, stack_top, tp;
   ccdo_pkg::ccdo_push_t stack_push;
   ccdo_pkg::ccdo_flags_t flags_q;
   logic [7:0] accum_q, watchdog_counter, prescaler_q, acc, r;
   logic [7:0] mem [128];
   logic [6:0] a;
   logic [6:0] dbg_addr = 7'h00;
   logic [7:0] dbg_data;
   logic z;
   ccdo_exp_t exp_q[$];
   ccdo_exp_t e, x, s;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   always #2.5 mclk = ~mclk;
   ccdo_core dut (.mclk, .rst, .instr, .instr_ready, .upper_pc_latch, .pc_q, .stack_push,
      .stack_top, .accum_q, .flags_q, .watchdog_counter, .prescaler_q, .watchdog_tick,
      .discard_q, .dbg_addr, .dbg_data);
   task report_and_stop;
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   // model one op, note the result, drive it
   task run(input ccdo_pkg::ccdo_op_t op, input logic d, input logic [10:0] k);
      e = '0;
      pc = pc + 13'h0001;
      r = (op == ccdo_pkg::CCDO_OP_FILE_INV) ? ~mem[a] : mem[a] - 8'h01;
      case (op)
         ccdo_pkg::CCDO_OP_CALL: begin
            e.push = 1'b1;
            e.ret = pc;
            tp = pc;
            pc = {upper_pc_latch[4:3], k};
         end
         ccdo_pkg::CCDO_OP_DOG_KICK: e.wd0 = 1'b1;
         ccdo_pkg::CCDO_OP_FILE_ZERO: {mem[a], z} = {8'h00, 1'b1};
         ccdo_pkg::CCDO_OP_ACC_ZERO: {acc, z} = {8'h00, 1'b1};
         default: begin
            if (d) mem[a] = r;
            else acc = r;
            if (op != ccdo_pkg::CCDO_OP_DEC_SKIP) z = (r == 8'h00);
            else if (r == 8'h00) {pc, e.disc} = {pc + 13'h0001, 1'b1};
         end
      endcase
      {e.acc, e.z, e.pc, e.top} = {acc, z, pc, tp};
      exp_q.push_back(e);
      instr <= '{1'b1, op, k, a, d};
      watchdog_tick <= 1'b0;
      @(posedge mclk);
      instr.valid <= 1'b0;
      @(posedge mclk);
      watchdog_tick <= 1'($urandom);
      upper_pc_latch <= 8'($urandom);
      repeat (2) @(posedge mclk);
   endtask : run
   always @(posedge mclk) begin
      t = instr.valid && instr_ready;
      cyc++;
      if (cyc > 1000) begin
         n_fail++;
         $display("BAD timeout expected 1000 seen %0d", cyc);
         report_and_stop();
      end
      if (tk) begin
         #1;
         x = exp_q.pop_front();
         s = {accum_q, flags_q.zero, pc_q, stack_push.push,
            stack_push.push ? stack_push.data : 13'h0000, discard_q,
            x.wd0 && watchdog_counter === 8'h00 && prescaler_q === 8'h00
            && flags_q.expiry_n === 1'b1 && flags_q.sleep_n === 1'b1, stack_top};
         cmp_count++;
         if (s !== x) begin
            n_fail++;
            $display("BAD result expected %h seen %h", x, s);
         end
      end
      tk = t;
   end
   initial begin
      {acc, z, pc, tk, tp} = '0;
      void'($urandom(62));
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 7'h7F : 7'($urandom);
         dbg_addr <= a;
         run(ccdo_pkg::CCDO_OP_FILE_ZERO, 1'b0, 11'h000);
         run(ccdo_pkg::CCDO_OP_FILE_DEC, 1'b1, 11'h000);
         run(ccdo_pkg::CCDO_OP_FILE_INV, 1'b0, 11'h000);
         run(ccdo_pkg::CCDO_OP_DEC_SKIP, 1'b0, 11'h000);
         run(ccdo_pkg::CCDO_OP_FILE_DEC, 1'b1, 11'h000);
         run(ccdo_pkg::CCDO_OP_FILE_INV, 1'b1, 11'h000);
         cmp_count++;
         if (dbg_data !== mem[a]) begin
            n_fail++;
            $display("BAD dbg_data expected %h seen %h", mem[a], dbg_data);
         end
         run(ccdo_pkg::CCDO_OP_DEC_SKIP, 1'b1, 11'h000);
         run(ccdo_pkg::CCDO_OP_FILE_INV, 1'b0, 11'h000);
         run(ccdo_pkg::CCDO_OP_ACC_ZERO, 1'b0, 11'h000);
         run(ccdo_pkg::CCDO_OP_DOG_KICK, 1'b0, 11'h000);
         run(ccdo_pkg::CCDO_OP_CALL, 1'b0, (i == 0) ? 11'h7FF : 11'($urandom));
      end
      repeat (4) @(posedge mclk);
      cmp_count++;
      if (exp_q.size() != 0) begin
         n_fail++;
         $display("BAD pending expected 0 seen %0d", exp_q.size());
      end
      report_and_stop();
   end
endmodule : test_ccdo_core
